// >>> core/rtu_defines.vh
// Register offsets, field positions, reset values and codes of the recorder trigger unit
`ifndef RTU_DEFINES_VH
`define RTU_DEFINES_VH
`define RTU_OFF_CTRL 12'h000
`define RTU_OFF_MODE 12'h004
`define RTU_OFF_SRC 12'h008
`define RTU_OFF_THR 12'h00c
`define RTU_OFF_PRE 12'h010
`define RTU_OFF_STAT 12'h014
`define RTU_OFF_IRQST 12'h018
`define RTU_OFF_IRQMSK 12'h01c
`define RTU_OFF_LIST 12'h020
`define RTU_OFF_PTR 12'h024
`define RTU_OFF_DEPTH 12'h028
`define RTU_OFF_RDIDX 12'h02c
`define RTU_CTRL_ARM 0
`define RTU_CTRL_STOP 1
`define RTU_CTRL_HOSTCMD 2
`define RTU_MODE_TYPE_LSB 0
`define RTU_MODE_SLOPE 2
`define RTU_MODE_FILL 3
`define RTU_TYPE_IMMEDIATE 2'h0
`define RTU_TYPE_COMMAND 2'h1
`define RTU_TYPE_CROSS 2'h2
`define RTU_TYPE_BOOL 2'h3
`define RTU_SRC_POS_ERR 3'h0
`define RTU_SRC_POS_CMD 3'h1
`define RTU_SRC_POS_FB 3'h2
`define RTU_SRC_VEL_CMD 3'h3
`define RTU_SRC_VEL_FB 3'h4
`define RTU_SRC_CUR_CMD 3'h5
`define RTU_SRC_CUR_FB 3'h6
`define RTU_SRC_MEM 3'h7
`define RTU_RST_SRC 3'h6
`define RTU_RST_PRE 7'h0a
`define RTU_PRE_MIN 7'h01
`define RTU_PRE_MAX 7'h64
`define RTU_SRC_LIST 32'h0000007f
`define RTU_IRQ_TRIG 0
`define RTU_IRQ_DONE 1
`define RTU_IRQ_REJ 2
`endif

// >>> core/rtu_trigger_unit.v
// Recorder trigger and arming logic with an APB register slave
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "rtu_defines.vh"

module rtu_trigger_unit #(
  parameter DW = 32,
  parameter AW = 16
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sampleTick,
  input wire [DW-1:0] positionError,
  input wire [DW-1:0] positionCommand,
  input wire [DW-1:0] positionFeedback,
  input wire [DW-1:0] velocityCommand,
  input wire [DW-1:0] velocityFeedback,
  input wire [DW-1:0] currentCommand,
  input wire [DW-1:0] currentFeedback,
  input wire [DW-1:0] memoryValue,
  output reg [31:0] memoryPointer,
  output reg recordEnable,
  output reg [AW-1:0] writeIndex,
  output reg sampleWrite,
  output reg [AW-1:0] triggerIndex,
  output reg bufferClear,
  output reg captureDone,
  output reg armed,
  output reg irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_POST = 2'h2;

  reg [1:0] state_q;
  reg [1:0] trigMode_q;
  reg edgeDir_q;
  reg fillPolicy_q;
  reg [2:0] srcSel_q;
  reg [DW-1:0] threshold_q;
  reg [6:0] prePct_q;
  reg [AW-1:0] depth_q;
  reg [AW-1:0] readIndex_q;
  reg [AW-1:0] preCount_q;
  reg [AW-1:0] postCount_q;
  reg [AW-1:0] filled_q;
  reg [DW-1:0] prevSample_q;
  reg prevValid_q;
  reg [2:0] irqStat_q;
  reg [2:0] irqMask_q;

  wire apbWrite = psel & penable & pwrite & pready;
  wire apbRead = psel & penable & ~pwrite & pready;
  wire cfgHit = (paddr == `RTU_OFF_MODE) | (paddr == `RTU_OFF_SRC) | (paddr == `RTU_OFF_THR) |
                (paddr == `RTU_OFF_PRE) | (paddr == `RTU_OFF_PTR) | (paddr == `RTU_OFF_DEPTH);
  wire cfgWrite = apbWrite & cfgHit & ~armed;
  wire cfgReject = apbWrite & cfgHit & armed;
  wire ctrlWrite = apbWrite & (paddr == `RTU_OFF_CTRL);
  wire armCmd = ctrlWrite & pwdata[`RTU_CTRL_ARM];
  wire stopCmd = ctrlWrite & pwdata[`RTU_CTRL_STOP] & ~pwdata[`RTU_CTRL_ARM];
  // Any other host command is the trigger for mode 1
  wire hostCmd = apbWrite & ~armCmd;

  // Source selection; memory pointer path is the eighth entry
  reg [DW-1:0] srcValue;
  always @* begin
    case (srcSel_q)
      `RTU_SRC_POS_ERR: srcValue = positionError;
      `RTU_SRC_POS_CMD: srcValue = positionCommand;
      `RTU_SRC_POS_FB: srcValue = positionFeedback;
      `RTU_SRC_VEL_CMD: srcValue = velocityCommand;
      `RTU_SRC_VEL_FB: srcValue = velocityFeedback;
      `RTU_SRC_CUR_CMD: srcValue = currentCommand;
      `RTU_SRC_CUR_FB: srcValue = currentFeedback;
      default: srcValue = memoryValue;
    endcase
  end

  // Signed compare in the source's own units
  wire signed [DW-1:0] sNow = srcValue;
  wire signed [DW-1:0] sPrev = prevSample_q;
  wire signed [DW-1:0] sThr = threshold_q;
  wire riseHit = prevValid_q & (sPrev < sThr) & (sNow >= sThr);
  wire fallHit = prevValid_q & (sPrev > sThr) & (sNow <= sThr);
  wire crossHit = edgeDir_q ? riseHit : fallHit;
  wire boolHit = edgeDir_q ? (srcValue == {{(DW-1){1'b0}}, 1'b1}) : (srcValue == {DW{1'b0}});

  reg trigHit;
  always @* begin
    case (trigMode_q)
      `RTU_TYPE_IMMEDIATE: trigHit = 1'b1;
      `RTU_TYPE_COMMAND: trigHit = hostCmd;
      `RTU_TYPE_CROSS: trigHit = sampleTick & crossHit;
      default: trigHit = sampleTick & boolHit;
    endcase
  end

  // Buffer split; product is widened so 100% of a full depth does not wrap
  wire [AW+6:0] preProd = depth_q * prePct_q;
  wire [AW+6:0] preFull = preProd / 7'd100;
  wire useSplit = (trigMode_q == `RTU_TYPE_CROSS) | (trigMode_q == `RTU_TYPE_BOOL) |
                  (trigMode_q == `RTU_TYPE_COMMAND);
  wire [AW-1:0] preLen = useSplit ? preFull[AW-1:0] : {AW{1'b0}};
  wire [AW-1:0] postLen = depth_q - preLen;
  wire [AW-1:0] wrNext = (writeIndex + 1'b1 >= depth_q) ? {AW{1'b0}} : writeIndex + 1'b1;
  wire preReady = (filled_q >= preLen);
  wire lastPost = (postCount_q + 1'b1 >= postLen);

  // Capture state machine
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      armed <= 1'b0;
      captureDone <= 1'b0;
      recordEnable <= 1'b0;
      writeIndex <= {AW{1'b0}};
      sampleWrite <= 1'b0;
      triggerIndex <= {AW{1'b0}};
      bufferClear <= 1'b0;
      readIndex_q <= {AW{1'b0}};
      postCount_q <= {AW{1'b0}};
      filled_q <= {AW{1'b0}};
      prevSample_q <= {DW{1'b0}};
      prevValid_q <= 1'b0;
    end else begin
      bufferClear <= 1'b0;
      sampleWrite <= 1'b0;
      if (sampleTick) begin
        prevSample_q <= srcValue;
        prevValid_q <= 1'b1;
      end
      if (armCmd) begin
        state_q <= ST_PRE;
        armed <= 1'b1;
        captureDone <= 1'b0;
        bufferClear <= 1'b1;
        readIndex_q <= {AW{1'b0}};
        writeIndex <= {AW{1'b0}};
        filled_q <= {AW{1'b0}};
        postCount_q <= {AW{1'b0}};
        recordEnable <= 1'b1;
        prevValid_q <= 1'b0; // Fresh history so a stale sample cannot fake a crossing
      end else if (stopCmd) begin
        state_q <= ST_IDLE;
        armed <= 1'b0;
        recordEnable <= 1'b0;
      end else begin
        if (apbRead & (paddr == `RTU_OFF_RDIDX) & ~armed) begin
          readIndex_q <= readIndex_q + 1'b1;
        end
        case (state_q)
          ST_PRE: begin
            if (sampleTick) begin
              sampleWrite <= 1'b1;
              writeIndex <= wrNext;
              if (filled_q < depth_q) begin
                filled_q <= filled_q + 1'b1;
              end
            end
            // Trigger only counts once the pre-trigger part holds real data
            if (trigHit & preReady) begin
              state_q <= ST_POST;
              triggerIndex <= writeIndex;
            end
          end
          ST_POST: begin
            if (sampleTick) begin
              sampleWrite <= 1'b1;
              writeIndex <= wrNext;
              postCount_q <= postCount_q + 1'b1;
              if (lastPost) begin
                if (fillPolicy_q) begin
                  state_q <= ST_IDLE;
                  armed <= 1'b0;
                  captureDone <= 1'b1;
                  recordEnable <= 1'b0;
                end else begin
                  postCount_q <= {AW{1'b0}};
                end
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Configuration registers, frozen while armed
  always @(posedge clk) begin
    if (rst) begin
      trigMode_q <= `RTU_TYPE_IMMEDIATE;
      edgeDir_q <= 1'b0;
      fillPolicy_q <= 1'b0;
      srcSel_q <= `RTU_RST_SRC;
      threshold_q <= {DW{1'b0}};
      prePct_q <= `RTU_RST_PRE;
      depth_q <= {AW{1'b1}};
      memoryPointer <= 32'h00000000;
    end else if (cfgWrite) begin
      case (paddr)
        `RTU_OFF_MODE: begin
          trigMode_q <= pwdata[`RTU_MODE_TYPE_LSB+1:`RTU_MODE_TYPE_LSB];
          edgeDir_q <= pwdata[`RTU_MODE_SLOPE];
          fillPolicy_q <= pwdata[`RTU_MODE_FILL];
        end
        `RTU_OFF_SRC: srcSel_q <= pwdata[2:0];
        `RTU_OFF_THR: threshold_q <= pwdata[DW-1:0];
        `RTU_OFF_PRE: begin
          // Out-of-range percent is clamped into 1..100
          if (pwdata[6:0] < `RTU_PRE_MIN) begin
            prePct_q <= `RTU_PRE_MIN;
          end else if (pwdata[31:7] != 25'h0000000 || pwdata[6:0] > `RTU_PRE_MAX) begin
            prePct_q <= `RTU_PRE_MAX;
          end else begin
            prePct_q <= pwdata[6:0];
          end
        end
        `RTU_OFF_PTR: memoryPointer <= pwdata;
        `RTU_OFF_DEPTH: begin
          if (pwdata[AW-1:0] != {AW{1'b0}}) begin
            depth_q <= pwdata[AW-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  wire [2:0] irqSet = {cfgReject, (state_q == ST_POST) & fillPolicy_q & sampleTick & lastPost & ~armCmd & ~stopCmd,
                       (state_q == ST_PRE) & trigHit & preReady & ~armCmd & ~stopCmd};
  wire [2:0] irqClr = (apbWrite & (paddr == `RTU_OFF_IRQST)) ? pwdata[2:0] : 3'h0;
  // Next mask value, so the line follows a mask write in the same edge and no stale level lingers
  wire [2:0] irqMask_d = (apbWrite & (paddr == `RTU_OFF_IRQMSK)) ? pwdata[2:0] : irqMask_q;
  always @(posedge clk) begin
    if (rst) begin
      irqStat_q <= 3'h0;
      irqMask_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
      irqMask_q <= irqMask_d;
      irq <= |(((irqStat_q & ~irqClr) | irqSet) & irqMask_d);
    end
  end

  // APB slave: one wait state, so every access completes in the second access cycle
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        pslverr <= (pwrite & cfgHit & armed) | ~(cfgHit | (paddr == `RTU_OFF_CTRL) |
                   (paddr == `RTU_OFF_STAT) | (paddr == `RTU_OFF_IRQST) | (paddr == `RTU_OFF_IRQMSK) |
                   (paddr == `RTU_OFF_LIST) | (paddr == `RTU_OFF_RDIDX));
        case (paddr)
          `RTU_OFF_MODE: prdata <= {28'h0000000, fillPolicy_q, edgeDir_q, trigMode_q};
          `RTU_OFF_SRC: prdata <= {29'h00000000, srcSel_q};
          `RTU_OFF_THR: prdata <= threshold_q;
          `RTU_OFF_PRE: prdata <= {25'h0000000, prePct_q};
          `RTU_OFF_STAT: prdata <= {28'h0000000, state_q, armed, captureDone};
          `RTU_OFF_IRQST: prdata <= {29'h00000000, irqStat_q};
          `RTU_OFF_IRQMSK: prdata <= {29'h00000000, irqMask_q};
          `RTU_OFF_LIST: prdata <= `RTU_SRC_LIST;
          `RTU_OFF_PTR: prdata <= memoryPointer;
          `RTU_OFF_DEPTH: prdata <= {{(32-AW){1'b0}}, depth_q};
          `RTU_OFF_RDIDX: prdata <= {{(32-AW){1'b0}}, readIndex_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> testbench/rtu_loop_source.sv
// Loop-signal source: a ramp stepped on every fourth clock
`timescale 1ns/100ps
module rtu_loop_source (
  input wire clk,
  input wire rst,
  input wire restart,
  output reg sampleTick,
  output reg [31:0] currentFeedback,
  output wire [31:0] positionError
);
  reg [1:0] divCount_q;
  // Boolean view of the ramp for the level trigger
  assign positionError = {31'h0, currentFeedback[2]};
  // Restart lets a test arm well before the ramp meets its threshold
  always @(posedge clk) begin
    if (rst || restart) begin
      divCount_q <= 2'h0;
      sampleTick <= 1'b0;
      currentFeedback <= 32'h0;
    end else begin
      divCount_q <= divCount_q + 2'h1;
      sampleTick <= divCount_q == 2'h3;
      if (divCount_q == 2'h3)
        currentFeedback <= currentFeedback + 32'h1;
    end
  end
endmodule

// >>> testbench/rtu_trigger_unit_asserts.sv
// Port-level checks of the recorder trigger unit
`timescale 1ns/100ps
`include "rtu_defines.vh"
module rtu_trigger_checker (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire bufferClear,
  input wire captureDone,
  input wire armed,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Completed transfers; the lockable window is every setting register
  wire acc = psel && penable && pready;
  wire armWr = acc && pwrite && paddr == `RTU_OFF_CTRL && pwdata[0];
  wire cfgWr = acc && pwrite && ((paddr >= `RTU_OFF_MODE && paddr <= `RTU_OFF_PRE) ||
    paddr == `RTU_OFF_PTR || paddr == `RTU_OFF_DEPTH);
  reg [1:0] mode_q;
  reg fill_q;
  reg [2:0] mask_q;
  // Shadow of accepted writes, so refused ones never move it
  always @(posedge clk) begin
    if (rst) begin
      mode_q <= 2'h0;
      fill_q <= 1'b0;
      mask_q <= 3'h0;
    end else if (acc && pwrite && !pslverr) begin
      if (paddr == `RTU_OFF_MODE) begin
        mode_q <= pwdata[1:0];
        fill_q <= pwdata[3];
      end
      if (paddr == `RTU_OFF_IRQMSK)
        mask_q <= pwdata[2:0];
    end
  end
  a_arm_clears_done: assert property (armWr |=> !captureDone && armed)
    else $error("arm did not clear done");
  a_arm_discards_old: assert property (armWr |-> ##[1:2] bufferClear)
    else $error("arm did not discard old capture");
  a_locked_config_refused: assert property (armed && cfgWr |-> pslverr)
    else $error("setting write accepted while armed");
  a_refusal_raises_irq: assert property (armed && cfgWr && mask_q[2] |-> ##[1:3] irq)
    else $error("refused write gave no interrupt");
  a_immediate_trigger: assert property (armWr && mode_q == 2'h0 && mask_q[0] |-> ##[1:4] irq)
    else $error("immediate mode did not trigger");
  a_source_list_fixed: assert property (acc && !pwrite && paddr == `RTU_OFF_LIST |->
    prdata == `RTU_SRC_LIST && !pslverr)
    else $error("source list read wrong");
  a_circular_never_done: assert property (armed && !fill_q |=> !captureDone)
    else $error("circular fill reported done");
  a_done_releases_lock: assert property ($rose(captureDone) |-> !armed)
    else $error("done without releasing lock");
endmodule

// >>> testbench/rtu_trigger_unit_tb_top.sv
// Self-checking bench for the recorder trigger unit
`timescale 1ns/100ps
`include "rtu_defines.vh"
module rtu_trigger_unit_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg restart = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  wire [31:0] memPtr;
  reg er;
  wire [31:0] prdata, positionError, positionCommand, positionFeedback, velocityCommand;
  wire [31:0] velocityFeedback, currentCommand, currentFeedback, memoryValue;
  wire pready, pslverr, sampleTick, bufferClear, captureDone, armed, irq;
  int fails = 0;
  int compares = 0;
  // Every source input follows the ramp so none is a constant
  assign positionCommand = ~currentFeedback;
  assign positionFeedback = currentFeedback << 1;
  assign velocityCommand = currentFeedback ^ 32'h55;
  assign velocityFeedback = -currentFeedback;
  assign currentCommand = currentFeedback >> 1;
  assign memoryValue = currentFeedback + 32'h3;
  rtu_loop_source src (.clk, .rst, .restart, .sampleTick, .currentFeedback, .positionError);
  rtu_trigger_unit DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sampleTick, .positionError, .positionCommand, .positionFeedback, .velocityCommand, .velocityFeedback,
    .currentCommand, .currentFeedback, .memoryValue, .memoryPointer(memPtr), .recordEnable(), .writeIndex(),
    .sampleWrite(), .triggerIndex(), .bufferClear, .captureDone, .armed, .irq);
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      compares++;
      if (s !== e) begin
        fails++;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task xfer(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input e);
    begin
      xfer(a, 1'b1, d);
      chk("pslverr", {31'h0, e}, {31'h0, er});
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk($sformatf("read %h", a), e, rd);
    end
  endtask
  // Bounded wait; the watchdog is the backstop
  task waitIrq(input int lim);
    int n;
    begin
      // Let one edge pass so a level left over from the last write is not taken
      @(posedge clk);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
        @(posedge clk);
        n++;
      end
      chk("irq", 32'h1, {31'h0, irq});
    end
  endtask
  // Clear stale events first, else the old ones fire at once
  task irqSel(input [2:0] m);
    begin
      wr(`RTU_OFF_IRQST, 32'h7, 1'b0);
      wr(`RTU_OFF_IRQMSK, {29'h0, m}, 1'b0);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude;
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(`RTU_OFF_MODE, 32'h0);
    rdc(`RTU_OFF_SRC, {29'h0, `RTU_SRC_CUR_FB});
    rdc(`RTU_OFF_THR, 32'h0);
    rdc(`RTU_OFF_PRE, 32'h0a);
    rdc(`RTU_OFF_LIST, `RTU_SRC_LIST);
    wr(`RTU_OFF_SRC, {29'h0, `RTU_SRC_MEM}, 1'b0);
    rdc(`RTU_OFF_SRC, {29'h0, `RTU_SRC_MEM});
    wr(`RTU_OFF_PTR, 32'h100, 1'b0);
    rdc(`RTU_OFF_PTR, 32'h100);
    chk("pointer", 32'h100, memPtr);
    wr(`RTU_OFF_SRC, {29'h0, `RTU_SRC_CUR_FB}, 1'b0);
    wr(`RTU_OFF_PRE, 32'h0, 1'b0);
    rdc(`RTU_OFF_PRE, 32'h1);
    wr(`RTU_OFF_PRE, 32'hc8, 1'b0);
    rdc(`RTU_OFF_PRE, 32'h64);
    wr(`RTU_OFF_PRE, 32'h0a, 1'b0);
    wr(`RTU_OFF_DEPTH, 32'h8, 1'b0);
    $display("test settings done");
    wr(`RTU_OFF_MODE, 32'h8, 1'b0);
    rdc(`RTU_OFF_RDIDX, 32'h0);
    rdc(`RTU_OFF_RDIDX, 32'h1);
    irqSel(3'h2);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    rdc(`RTU_OFF_RDIDX, 32'h0);
    wr(`RTU_OFF_THR, 32'h5, 1'b1);
    waitIrq(200);
    chk("armed", 32'h0, {31'h0, armed});
    rdc(`RTU_OFF_THR, 32'h0);
    $display("test single fill done");
    wr(`RTU_OFF_MODE, 32'h0, 1'b0);
    irqSel(3'h1);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    waitIrq(50);
    irqSel(3'h4);
    wr(`RTU_OFF_THR, 32'h5, 1'b1);
    waitIrq(50);
    repeat (100) @(posedge clk);
    chk("circular done", 32'h0, {31'h0, captureDone});
    wr(`RTU_OFF_CTRL, 32'h2, 1'b0);
    repeat (2) @(posedge clk);
    chk("armed", 32'h0, {31'h0, armed});
    wr(`RTU_OFF_THR, 32'h14, 1'b0);
    $display("test circular done");
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    wr(`RTU_OFF_MODE, 32'he, 1'b0);
    irqSel(3'h1);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    waitIrq(400);
    chk("cross", 32'h1, {31'h0, currentFeedback >= 32'h14 && currentFeedback <= 32'h15});
    wr(`RTU_OFF_IRQMSK, 32'h2, 1'b0);
    waitIrq(200);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    wr(`RTU_OFF_MODE, 32'ha, 1'b0);
    irqSel(3'h1);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    repeat (200) @(posedge clk);
    rdc(`RTU_OFF_IRQST, 32'h0);
    wr(`RTU_OFF_CTRL, 32'h2, 1'b0);
    $display("test crossing done");
    wr(`RTU_OFF_SRC, {29'h0, `RTU_SRC_POS_ERR}, 1'b0);
    wr(`RTU_OFF_MODE, 32'hf, 1'b0);
    irqSel(3'h1);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    waitIrq(200);
    wr(`RTU_OFF_IRQMSK, 32'h2, 1'b0);
    waitIrq(200);
    $display("test level done");
    wr(`RTU_OFF_MODE, 32'h9, 1'b0);
    irqSel(3'h1);
    wr(`RTU_OFF_CTRL, 32'h1, 1'b0);
    repeat (60) @(posedge clk);
    chk("early trigger", 32'h0, {31'h0, irq});
    wr(`RTU_OFF_CTRL, 32'h0, 1'b0);
    waitIrq(100);
    $display("test command done");
    conclude;
  end
endmodule
bind rtu_trigger_unit rtu_trigger_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .bufferClear, .captureDone, .armed, .irq);
